// File: core/pps_pkg.sv
/*
  Package for the pump pressure sleep sequencer: register map, field
  positions, reset values, timing counts and the sequencer states.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package pps_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_SEC    = 1000000000;
  localparam int CYC_PER_SEC   = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN   = 60;
  localparam int SLEEP_WAIT_S  = 6;

  // ----------------------------------------------------------------
  // register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam int REG_CTRL  = 0;
  localparam int REG_SP01  = 1;
  localparam int REG_SP23  = 2;
  localparam int REG_SLP   = 3;
  localparam int REG_MRG   = 4;
  localparam int REG_BST   = 5;
  localparam int REG_PCH   = 6;
  localparam int REG_PCHP  = 7;
  localparam int REG_BP    = 8;
  localparam int REG_IMASK = 9;
  localparam int NCFG      = 10;
  localparam int REG_STAT  = 10;
  localparam int REG_ISTAT = 11;
  localparam int NREG      = 12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN   = 0;
  localparam int CTRL_ACP  = 1;
  localparam int CTRL_TCLR = 2;
  localparam int CTRL_SEL  = 4;
  localparam int HALF_LO   = 0;
  localparam int HALF_HI   = 16;
  localparam int SLP_OFF   = 0;
  localparam int SLP_FMIN  = 8;
  localparam int SLP_MINON = 16;
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE  = 1;
  localparam int IRQ_BP    = 2;
  localparam int IRQ_PCH   = 3;
  localparam int IRQ_W     = 4;

  // ----------------------------------------------------------------
  // reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST [NCFG] = '{
    32'h0000_0000, 32'h0032_0032, 32'h0032_0032, 32'h0000_0A07,
    32'h0005_0014, 32'h0003_0000, 32'h0000_001E, 32'h0000_0014,
    32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] CFG_WMASK [NCFG] = '{
    32'h0000_0037, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_FFFF,
    32'hFFFF_FFFF, 32'h00FF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
    32'hFFFF_FFFF, 32'h0000_000F};

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRECH, ST_RUN, ST_BOOST, ST_SLEEP, ST_FAULT
  } pps_state_t;

endpackage

// File: core/pps_tick.sv
/*
  Second and minute tick generator for all sequencer timers.
  Assumes one system clock; clr restarts both dividers.
*/
`timescale 1ns/1ps
module pps_tick
  import pps_pkg::*;
#(
  parameter int CLK_PER_SEC = CYC_PER_SEC
)(
  input  wire logic   pclk,
  input  wire logic   presetn,
  pps_tick_if.gen     tif
);

  if (CLK_PER_SEC < 2)
  begin : g_chk
    $error("pps_tick: CLK_PER_SEC must be at least 2");
  end

  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic [5:0]  sec_r;
  logic [5:0]  sec_nxt;
  logic        stick_r;
  logic        stick_nxt;
  logic        mtick_r;
  logic        mtick_nxt;

  always_comb
  begin
    div_nxt   = div_r + 32'h0000_0001;
    sec_nxt   = sec_r;
    stick_nxt = 1'b0;
    mtick_nxt = 1'b0;
    if (tif.clr)
    begin
      div_nxt = 32'h0000_0000;
      sec_nxt = 6'h00;
    end
    else if (div_r == 32'(CLK_PER_SEC - 1))
    begin
      div_nxt   = 32'h0000_0000;
      stick_nxt = 1'b1;
      if (sec_r == 6'(SEC_PER_MIN - 1))
      begin
        sec_nxt   = 6'h00;
        mtick_nxt = 1'b1;
      end
      else
        sec_nxt = sec_r + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r   <= 32'h0000_0000;
      sec_r   <= 6'h00;
      stick_r <= 1'b0;
      mtick_r <= 1'b0;
    end
    else
    begin
      div_r   <= div_nxt;
      sec_r   <= sec_nxt;
      stick_r <= stick_nxt;
      mtick_r <= mtick_nxt;
    end
  end

  assign tif.sec_tick = stick_r;
  assign tif.min_tick = mtick_r;

endmodule

// File: core/pps_tick_if.sv
/*
  Tick bundle between the sequencer and its tick generator.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface pps_tick_if;
  logic clr;
  logic sec_tick;
  logic min_tick;
  modport gen      (input clr, output sec_tick, output min_tick);
  modport use_side (output clr, input sec_tick, input min_tick);
endinterface

// File: core/pps_top.sv
/*
  Pump pressure sleep sequencer with APB register file and interrupt.
  Assumes 40 MHz pclk; meas_in and out_freq_in come from another domain,
  pid_freq from the regulation loop on pclk.
*/
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
#(
  parameter int CLK_PER_SEC = CYC_PER_SEC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] meas_in,
  input  wire logic [15:0] out_freq_in,
  input  wire logic [15:0] pid_freq,
  output logic             motor_run,
  output logic      [15:0] freq_cmd,
  output logic      [15:0] reg_target,
  output logic             boost_active,
  output logic             prech_active,
  output logic             sleeping,
  output logic             bp_fault,
  output logic             irq
);

  function automatic logic [16:0] sum17(input logic [15:0] a, input logic [15:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic is_run(input pps_state_t s);
    return (s == ST_PRECH) || (s == ST_RUN) || (s == ST_BOOST);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]      cfg_r [NCFG];
  logic [31:0]      cfg_nxt [NCFG];
  logic [15:0]      meas_m_r, meas_s_r, fout_m_r, fout_s_r;
  pps_state_t       st_r, st_nxt;
  logic [2:0]       wait_r, wait_nxt;
  logic [7:0]       on_r, on_nxt, bst_r, bst_nxt;
  logic [15:0]      pch_r, pch_nxt, bpc_r, bpc_nxt;
  logic [IRQ_W-1:0] istat_r, istat_nxt, ev;
  logic [31:0]      prdata_r, prdata_nxt;
  logic             pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic             tclr_r, tclr_nxt, irq_r, irq_nxt;
  logic             run_r, run_nxt, fault_r, fault_nxt;
  logic [15:0]      freq_r, freq_nxt, tgt_r, tgt_nxt;
  logic             bact_r, bact_nxt, pact_r, pact_nxt, slp_r, slp_nxt;

  pps_tick_if tif ();

  pps_tick #(
    .CLK_PER_SEC (CLK_PER_SEC)
  ) u_tick (
    .pclk        (pclk),
    .presetn     (presetn),
    .tif         (tif)
  );
  assign tif.clr = tclr_r;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic        en, acp;
  logic [1:0]  sel;
  logic [15:0] sp_act, force_m, wake_m, bst_amt, pch_f, pch_p, bp_lvl;
  logic [15:0] pch_t, bp_t;
  logic [7:0]  s_off, f_min, min_on, bst_t;
  logic [31:0] sp_w;

  assign en      = cfg_r[REG_CTRL][CTRL_EN];
  assign acp     = cfg_r[REG_CTRL][CTRL_ACP];
  assign sel     = cfg_r[REG_CTRL][CTRL_SEL +: 2];
  assign sp_w    = sel[1] ? cfg_r[REG_SP23] : cfg_r[REG_SP01];
  assign sp_act  = sel[0] ? sp_w[HALF_HI +: 16] : sp_w[HALF_LO +: 16];
  assign s_off   = cfg_r[REG_SLP][SLP_OFF +: 8];
  assign f_min   = cfg_r[REG_SLP][SLP_FMIN +: 8];
  assign min_on  = cfg_r[REG_SLP][SLP_MINON +: 8];
  assign force_m = cfg_r[REG_MRG][HALF_LO +: 16];
  assign wake_m  = cfg_r[REG_MRG][HALF_HI +: 16];
  assign bst_amt = cfg_r[REG_BST][HALF_LO +: 16];
  assign bst_t   = cfg_r[REG_BST][HALF_HI +: 8];
  assign pch_f   = cfg_r[REG_PCH][HALF_LO +: 16];
  assign pch_t   = cfg_r[REG_PCH][HALF_HI +: 16];
  assign pch_p   = cfg_r[REG_PCHP][HALF_LO +: 16];
  assign bp_lvl  = cfg_r[REG_BP][HALF_LO +: 16];
  assign bp_t    = cfg_r[REG_BP][HALF_HI +: 16];

  // ----------------------------------------------------------------
  // conditions
  // ----------------------------------------------------------------
  logic [16:0] bst_sum;
  logic        force_hit, wake_hit, sleep_cond, pch_done, bst_done, bp_cond, bp_fire;

  assign bst_sum    = sum17(sp_act, bst_amt);
  assign force_hit  = {1'b0, meas_s_r} >= sum17(sp_act, force_m);
  assign wake_hit   = sum17(meas_s_r, wake_m) < {1'b0, sp_act};
  assign sleep_cond = (st_r == ST_RUN) && (meas_s_r >= sp_act) && (on_r >= min_on)
                   && ({1'b0, fout_s_r} <= sum17({8'h00, f_min}, {8'h00, s_off}));
  assign pch_done   = (pch_r >= pch_t) || (acp && (meas_s_r >= pch_p));
  assign bst_done   = (bst_r >= bst_t) || ({1'b0, meas_s_r} >= bst_sum);
  assign bp_cond    = (bp_lvl != 16'h0000) && (bp_t != 16'h0000) && run_r
                   && (meas_s_r < bp_lvl);
  assign bp_fire    = bp_cond && (bpc_r >= bp_t);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (en)
          st_nxt = (pch_t != 16'h0000) ? ST_PRECH : ST_RUN;
      ST_PRECH:
        if (pch_done)
          st_nxt = ST_RUN;
      ST_RUN:
        if (sleep_cond && (wait_r >= 3'(SLEEP_WAIT_S)))
          st_nxt = (bst_amt != 16'h0000) ? ST_BOOST : ST_SLEEP;
      ST_BOOST:
        if (bst_done)
          st_nxt = ST_SLEEP;
      ST_SLEEP:
        if (wake_hit)
          st_nxt = ST_RUN;
      ST_FAULT:
        st_nxt = ST_FAULT;
      default:
        st_nxt = ST_IDLE;
    endcase
    if (is_run(st_r) && force_hit)
      st_nxt = ST_SLEEP;
    if (bp_fire)
      st_nxt = ST_FAULT;
    if (!en)
      st_nxt = ST_IDLE;
  end

  // ----------------------------------------------------------------
  // timers and outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    wait_nxt  = wait_r;
    on_nxt    = on_r;
    bst_nxt   = bst_r;
    pch_nxt   = pch_r;
    bpc_nxt   = bpc_r;
    if (!sleep_cond)
      wait_nxt = 3'h0;
    else if (tif.sec_tick && (wait_r < 3'(SLEEP_WAIT_S)))
      wait_nxt = wait_r + 3'h1;
    if (!is_run(st_r))
      on_nxt = 8'h00;
    else if (tif.sec_tick && (on_r != 8'hFF))
      on_nxt = on_r + 8'h01;
    if (st_r != ST_BOOST)
      bst_nxt = 8'h00;
    else if (tif.sec_tick && (bst_r != 8'hFF))
      bst_nxt = bst_r + 8'h01;
    if (st_r != ST_PRECH)
      pch_nxt = 16'h0000;
    else if (tif.min_tick && (pch_r != 16'hFFFF))
      pch_nxt = pch_r + 16'h0001;
    if (!bp_cond)
      bpc_nxt = 16'h0000;
    else if (tif.min_tick && (bpc_r != 16'hFFFF))
      bpc_nxt = bpc_r + 16'h0001;
    if (tclr_r)
    begin
      wait_nxt = 3'h0;
      on_nxt   = 8'h00;
      bst_nxt  = 8'h00;
      pch_nxt  = 16'h0000;
      bpc_nxt  = 16'h0000;
    end
    run_nxt   = is_run(st_nxt);
    fault_nxt = (st_nxt == ST_FAULT);
    bact_nxt  = (st_nxt == ST_BOOST);
    pact_nxt  = (st_nxt == ST_PRECH);
    slp_nxt   = (st_nxt == ST_SLEEP);
    freq_nxt  = 16'h0000;
    if (st_nxt == ST_PRECH)
      freq_nxt = (pid_freq > pch_f) ? pch_f : pid_freq;
    else if (run_nxt)
      freq_nxt = pid_freq;
    if (st_nxt == ST_BOOST)
      tgt_nxt = bst_sum[16] ? 16'hFFFF : bst_sum[15:0];
    else
      tgt_nxt = sp_act;
  end

  // ----------------------------------------------------------------
  // apb slave and interrupt
  // ----------------------------------------------------------------
  logic       acc;
  logic [3:0] idx;
  assign acc = psel && penable && pready_r;
  assign idx = paddr[5:2];

  always_comb
  begin
    cfg_nxt     = cfg_r;
    tclr_nxt    = 1'b0;
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    ev = '0;
    ev[IRQ_SLEEP] = (st_nxt == ST_SLEEP) && (st_r != ST_SLEEP);
    ev[IRQ_WAKE]  = (st_r == ST_SLEEP) && (st_nxt == ST_RUN);
    ev[IRQ_BP]    = (st_nxt == ST_FAULT) && (st_r != ST_FAULT);
    ev[IRQ_PCH]   = (st_r == ST_PRECH) && (st_nxt != ST_PRECH);
    istat_nxt = istat_r;
    if (acc && pwrite && (int'(idx) < NCFG) && (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00))
    begin
      cfg_nxt[idx] = pwdata & CFG_WMASK[idx];
      if (idx == 4'(REG_CTRL))
      begin
        tclr_nxt = pwdata[CTRL_TCLR];
        cfg_nxt[idx][CTRL_TCLR] = 1'b0;
      end
    end
    // only bits already reported are cleared, new events survive
    if (acc && !pwrite && (paddr == 8'(REG_ISTAT * 4)))
      istat_nxt = istat_r & ~prdata_r[IRQ_W-1:0];
    istat_nxt = istat_nxt | ev;
    if (psel && !penable)
    begin
      prdata_nxt = 32'h0000_0000;
      if (paddr[1:0] != 2'b00 || paddr[7:6] != 2'b00 || int'(idx) >= NREG)
        pslverr_nxt = 1'b1;
      else if (int'(idx) < NCFG)
        prdata_nxt = cfg_r[idx];
      else if (idx == 4'(REG_STAT))
        prdata_nxt = {27'h0000000, fault_r, run_r, st_r};
      else
        prdata_nxt = {28'h0000000, istat_r};
    end
    else if (!psel)
      pslverr_nxt = 1'b0;
    else
      pslverr_nxt = pslverr_r;
    irq_nxt = |(istat_nxt & cfg_r[REG_IMASK][IRQ_W-1:0]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r     <= CFG_RST;
      meas_m_r  <= 16'h0000;
      meas_s_r  <= 16'h0000;
      fout_m_r  <= 16'h0000;
      fout_s_r  <= 16'h0000;
      st_r      <= ST_IDLE;
      wait_r    <= 3'h0;
      on_r      <= 8'h00;
      bst_r     <= 8'h00;
      pch_r     <= 16'h0000;
      bpc_r     <= 16'h0000;
      istat_r   <= '0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      tclr_r    <= 1'b0;
      irq_r     <= 1'b0;
      run_r     <= 1'b0;
      fault_r   <= 1'b0;
      freq_r    <= 16'h0000;
      tgt_r     <= 16'h0000;
      bact_r    <= 1'b0;
      pact_r    <= 1'b0;
      slp_r     <= 1'b0;
    end
    else
    begin
      cfg_r     <= cfg_nxt;
      meas_m_r  <= meas_in;
      meas_s_r  <= meas_m_r;
      fout_m_r  <= out_freq_in;
      fout_s_r  <= fout_m_r;
      st_r      <= st_nxt;
      wait_r    <= wait_nxt;
      on_r      <= on_nxt;
      bst_r     <= bst_nxt;
      pch_r     <= pch_nxt;
      bpc_r     <= bpc_nxt;
      istat_r   <= istat_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      tclr_r    <= tclr_nxt;
      irq_r     <= irq_nxt;
      run_r     <= run_nxt;
      fault_r   <= fault_nxt;
      freq_r    <= freq_nxt;
      tgt_r     <= tgt_nxt;
      bact_r    <= bact_nxt;
      pact_r    <= pact_nxt;
      slp_r     <= slp_nxt;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign motor_run    = run_r;
  assign freq_cmd     = freq_r;
  assign reg_target   = tgt_r;
  assign boost_active = bact_r;
  assign prech_active = pact_r;
  assign sleeping     = slp_r;
  assign bp_fault     = fault_r;
  assign irq          = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready_r && psel && penable;
  endsequence

  AST_APB_ZERO_WAIT: assert property (s_setup |=> s_answer or !penable)
    else $error("apb access not answered at first access cycle");
  AST_SLEEP_WAIT: assert property (st_r == ST_RUN && !force_hit && !bp_fire && en
    && (st_nxt == ST_SLEEP || st_nxt == ST_BOOST) |-> wait_r >= 3'(SLEEP_WAIT_S))
    else $error("sleep entered before wait expired");
  AST_FORCE_STOP: assert property (is_run(st_r) && force_hit && en |=> !run_r)
    else $error("motor kept running above forced-stop level");
  AST_WAKE: assert property (st_r == ST_SLEEP && wake_hit && en |=> run_r)
    else $error("no wake below wake level");
  AST_BOOST_TGT: assert property (st_r == ST_BOOST |-> tgt_r ==
    ($past(bst_sum[16]) ? 16'hFFFF : $past(sp_act) + $past(bst_amt)))
    else $error("boost target wrong");
  AST_BOOST_END: assert property (st_r == ST_BOOST && bst_r >= bst_t && en && !bp_fire
    |=> st_r == ST_SLEEP)
    else $error("boost outlived its time");
  AST_PCH_CAP: assert property (st_r == ST_PRECH |-> freq_r <= $past(pch_f))
    else $error("precharge frequency above ceiling");
  AST_PCH_OFF: assert property (st_r == ST_IDLE && en && pch_t == 16'h0000
    |=> st_r != ST_PRECH)
    else $error("precharge entered with zero time");
  AST_PCH_EARLY: assert property (st_r == ST_PRECH && acp && meas_s_r >= pch_p && en
    && !force_hit && !bp_fire |=> st_r == ST_RUN)
    else $error("precharge not ended at target pressure");
  AST_BP_OFF: assert property (bp_lvl == 16'h0000 || bp_t == 16'h0000 |=> bpc_r == 16'h0000
    ##0 st_r != ST_FAULT || $past(st_r) == ST_FAULT)
    else $error("broken-pipe timer ran while disabled");
  AST_BP_RESTART: assert property (!bp_cond |=> bpc_r == 16'h0000)
    else $error("broken-pipe timer not restarted");
  AST_TCLR: assert property (tclr_r |=> wait_r == 3'h0 && pch_r == 16'h0000
    && bst_r == 8'h00)
    else $error("timers not cleared");

endmodule

// File: test/pps_plant.sv
/*
  Far-side model: pressure transducer and motor output stage.
  Assumes the bench sets the process value; frequency follows the command.
*/
`timescale 1ns/1ps
module pps_plant
#(
  parameter logic [15:0] SPAN = 16'h01F4
)(
  input  wire logic        pclk,
  input  wire logic        motor_run,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] meas_set,
  output logic      [15:0] meas_in,
  output logic      [15:0] out_freq_in
);
  always_ff @(posedge pclk)
  begin
    meas_in     <= (meas_set > SPAN) ? SPAN : meas_set;
    out_freq_in <= motor_run ? freq_cmd : 16'h0000;
  end
endmodule

// File: test/pps_top_tb.sv
/*
  Self-checking bench for the pump sleep sequencer top.
  Assumes pps_pkg, the design and the plant model compiled first.
*/
`timescale 1ns/1ps
module pps_top_tb
  import pps_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rd_err, motor_run, boost_active, prech_active, sleeping;
  logic        bp_fault, irq;
  logic [15:0] meas_set, meas_in, out_freq_in, pid_freq, freq_cmd, reg_target;
  int          err_count, compares, n;

  pps_plant i_pps_plant (.pclk(pclk), .motor_run(motor_run), .freq_cmd(freq_cmd),
    .meas_set(meas_set), .meas_in(meas_in), .out_freq_in(out_freq_in));

  pps_top #(.CLK_PER_SEC(10)) i_pps_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_in(meas_in), .out_freq_in(out_freq_in), .pid_freq(pid_freq),
    .motor_run(motor_run), .freq_cmd(freq_cmd), .reg_target(reg_target),
    .boost_active(boost_active), .prech_active(prech_active),
    .sleeping(sleeping), .bp_fault(bp_fault), .irq(irq));

  always #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input int idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= 8'(idx * 4);
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] exp [5];
    exp = '{32'h0032_0032, 32'h0032_0032, 32'h0000_0A07, 32'h0005_0014,
            32'h0003_0000};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, REG_SP01 + i, 32'h0);
      chk(rd, exp[i]);
    end
    apb(1'b0, 12, 32'h0);
    chk(rd_err, 1'b1);
    chk(rd, 32'h0000_0000);
    // setpoint three selected
    apb(1'b1, REG_SP23, 32'h0041_0032);
    apb(1'b1, REG_CTRL, 32'h0000_0030);
    apb(1'b0, REG_SP23, 32'h0);
    chk(rd, 32'h0041_0032);
    chk(reg_target, 16'd65);
  endtask

  task automatic t_prech;
    pid_freq <= 16'd50;
    apb(1'b1, REG_PCH, 32'h0001_001E);
    apb(1'b1, REG_CTRL, 32'h3);
    cyc(5);
    chk({prech_active, freq_cmd}, {1'b1, 16'd30});
    meas_set <= 16'd20;
    cyc(6);
    chk({prech_active, motor_run}, 2'b01);
    apb(1'b1, REG_CTRL, 32'h0);
    meas_set <= 16'd25;
    apb(1'b1, REG_CTRL, 32'h5);
    cyc(570);
    chk(prech_active, 1'b1);
    cyc(60);
    chk({prech_active, motor_run}, 2'b01);
    apb(1'b1, REG_PCH, 32'h0000_001E);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    cyc(3);
    chk({prech_active, motor_run}, 2'b01);
  endtask

  task automatic t_sleep;
    pid_freq <= 16'd17;
    meas_set <= 16'd50;
    apb(1'b1, REG_IMASK, 32'h1);
    apb(1'b0, REG_ISTAT, 32'h0);
    apb(1'b1, REG_CTRL, 32'h5);
    cyc(50);
    chk(sleeping, 1'b0);
    cyc(30);
    chk({sleeping, irq}, 2'b11);
    apb(1'b0, REG_ISTAT, 32'h0);
    chk(rd[0], 1'b1);
    cyc(3);
    chk(irq, 1'b0);
  endtask

  task automatic t_wake_force;
    meas_set <= 16'd45;
    cyc(8);
    chk(sleeping, 1'b1);
    meas_set <= 16'd44;
    cyc(8);
    chk({sleeping, motor_run}, 2'b01);
    pid_freq <= 16'd50;
    meas_set <= 16'd69;
    cyc(8);
    chk(sleeping, 1'b0);
    meas_set <= 16'd70;
    cyc(8);
    chk({sleeping, motor_run}, 2'b10);
    meas_set <= 16'd40;
    cyc(8);
  endtask

  task automatic t_boost;
    pid_freq <= 16'd17;
    apb(1'b1, REG_BST, 32'h0003_000A);
    meas_set <= 16'd50;
    apb(1'b1, REG_CTRL, 32'h5);
    for (n = 0; n < 100 && boost_active !== 1'b1; n++)
      @(posedge pclk);
    chk({boost_active, reg_target}, {1'b1, 16'd60});
    cyc(15);
    chk(boost_active, 1'b1);
    cyc(25);
    chk({boost_active, sleeping}, 2'b01);
  endtask

  task automatic t_bpipe;
    pid_freq <= 16'd50;
    meas_set <= 16'd10;
    cyc(8);
    apb(1'b1, REG_BP, 32'h0001_001E);
    apb(1'b1, REG_IMASK, 32'h4);
    apb(1'b1, REG_CTRL, 32'h5);
    cyc(560);
    chk(bp_fault, 1'b0);
    cyc(80);
    chk({bp_fault, irq}, 2'b11);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_BP, 32'h0001_0000);
    apb(1'b1, REG_CTRL, 32'h5);
    cyc(640);
    chk({bp_fault, motor_run}, 2'b01);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas_set = 16'h0000;
    pid_freq = 16'h0000;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prech();
    t_sleep();
    t_wake_force();
    t_boost();
    t_bpipe();
    complete_run();
  end

  initial
  begin
    #150000;
    err_count++;
    complete_run();
  end
endmodule
